//--- dv/motor_run_stop_command_logic_tb_top.sv
// Bench for the run and stop command logic
`timescale 1ns/1ps
`include "motor_cfg.svh"
module motor_run_stop_command_logic_tb_top;
  import motor_pkg::*;
  typedef struct {
    logic f, r, c;
    int   w;
    logic drv, rv;
    rpm_t spd;
    logic brk;
  } row_s;
  logic        ref_clk, rst_b, fwd_cmd, rev_cmd, coast_cmd, source_sel;
  logic        ce;
  logic        fwd_pin, rev_pin, coast_pin;
  logic [3:0]  avs_address, avs_byteenable;
  logic        avs_read, avs_write, avs_waitrequest;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic        motor_drive_on, motor_reverse, inst_stop_on;
  logic        brake_release_on, alarm_on;
  rpm_t        motor_speed;
  logic [7:0]  alarm_code;
  int          errors = 0;
  int          n_compared = 0;
  row_s rows[6] = '{
    '{1'h1, 1'h0, 1'h0, 2000, 1'h1, 1'h0, 11'h190, 1'h1},
    '{1'h0, 1'h0, 1'h0, 2000, 1'h0, 1'h0, 11'h000, 1'h0},
    '{1'h0, 1'h1, 1'h0, 2000, 1'h1, 1'h1, 11'h190, 1'h1},
    '{1'h1, 1'h1, 1'h0, 2000, 1'h0, 1'h0, 11'h000, 1'h0},
    '{1'h1, 1'h0, 1'h1, 200,  1'h0, 1'h0, 11'h000, 1'h1},
    '{1'h0, 1'h0, 1'h0, 200,  1'h0, 1'h0, 11'h000, 1'h0}};
  logic [31:0] cl_ctrl[4] = '{32'h1, 32'h5, 32'h1, 32'h0};
  rpm_t        cl_set[4]  = '{11'h7d0, 11'h7d0, 11'h032, 11'h032};
  rpm_t        cl_exp[4]  = '{11'h578, 11'h640, 11'h12c, 11'h05a};
  logic [3:0]  rv_adr[5]  = '{4'h0, 4'h4, 4'h8, 4'hc, 4'h2};
  logic [31:0] rv_exp[5]  = '{32'h1, 32'h12c, 32'h505, 32'h0, 32'h0};

  run_input_driver run_input_driver_i (
    .fwd_cmd(fwd_cmd), .rev_cmd(rev_cmd), .coast_cmd(coast_cmd),
    .source_sel(source_sel), .fwd_pin(fwd_pin), .rev_pin(rev_pin),
    .coast_pin(coast_pin));

  // Short counts keep halt, coast and ramps within a quick run
  motor_run_stop #(.HALT_CYCLES(20), .COAST_CYCLES(20), .STEP_CYCLES(2))
  motor_run_stop_i (
    .ref_clk(ref_clk), .rst_b(rst_b), .ce(ce),
    .forward_run_input(fwd_pin), .reverse_run_input(rev_pin),
    .coast_release_input(coast_pin),
    .input_polarity_selector(source_sel),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .motor_drive_on(motor_drive_on),
    .motor_reverse(motor_reverse), .motor_speed(motor_speed),
    .inst_stop_on(inst_stop_on), .brake_release_on(brake_release_on),
    .alarm_on(alarm_on), .alarm_code(alarm_code));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task chk(input string what, input logic [31:0] seen,
           input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : cyc

  task pins(input logic f, input logic r, input logic c);
    @(posedge ref_clk);
    fwd_cmd   <= f;
    rev_cmd   <= r;
    coast_cmd <= c;
  endtask : pins

  // Run pins settle well before release so the check sees them
  task do_reset(input logic f);
    @(posedge ref_clk);
    rst_b   <= 1'b0;
    fwd_cmd <= f;
    rev_cmd <= 1'b0;
    repeat (6) @(posedge ref_clk);
    rst_b   <= 1'b1;
  endtask : do_reset

  task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= ~wr;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    chk("bus_ack", avs_waitrequest, 32'h0);
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask : bus

  task end_of_test;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_of_test

  initial begin
    // Whole sequence takes about 55000 cycles
    repeat (80000) @(posedge ref_clk);
    errors++;
    end_of_test();
  end

  initial begin
    rst_b <= 1'b0;
    ce    <= 1'b1;
    {fwd_cmd, rev_cmd, coast_cmd, source_sel} <= 4'h0;
    {avs_read, avs_write} <= 2'h0;
    avs_address    <= 4'h0;
    avs_writedata  <= 32'h0;
    avs_byteenable <= 4'hf;
    do_reset(1'b0);
    bus(1'b1, 4'h4, 32'h190);
    bus(1'b1, 4'h8, 32'h202);
    for (int i = 0; i < 6; i++) begin
      pins(rows[i].f, rows[i].r, rows[i].c);
      cyc(rows[i].w);
      chk("drive", motor_drive_on, rows[i].drv);
      if (rows[i].drv)
        chk("reverse", motor_reverse, rows[i].rv);
      chk("speed", motor_speed, rows[i].spd);
      chk("brake", brake_release_on, rows[i].brk);
      $display("row %0d done", i);
    end
    pins(1'b1, 1'b0, 1'b0);
    cyc(2000);
    pins(1'b0, 1'b0, 1'b0);
    cyc(200);
    chk("decel", motor_drive_on && motor_speed > 11'h12c
        && motor_speed < 11'h190, 32'h1);
    cyc(2000);
    $display("decel ramp done");
    pins(1'b1, 1'b0, 1'b0);
    cyc(2000);
    pins(1'b1, 1'b1, 1'b0);
    cyc(8);
    chk("inst_stop", inst_stop_on, 32'h1);
    chk("halt_speed", motor_speed, 32'h0);
    pins(1'b0, 1'b0, 1'b0);
    cyc(60);
    chk("inst_end", inst_stop_on, 32'h0);
    $display("instant stop done");
    bus(1'b1, 4'h0, 32'h3);
    pins(1'b1, 1'b0, 1'b0);
    cyc(2000);
    pins(1'b0, 1'b0, 1'b0);
    cyc(8);
    bus(1'b0, 4'hc, 32'h0);
    chk("coast_state", rd[2:0], 32'h2);
    chk("coast_speed", motor_speed, 32'h0);
    cyc(60);
    chk("held", brake_release_on, 32'h0);
    $display("coast stop done");
    bus(1'b1, 4'h0, 32'h1);
    pins(1'b0, 1'b0, 1'b1);
    cyc(10);
    bus(1'b1, 4'h0, 32'h9);
    cyc(5);
    bus(1'b0, 4'h0, 32'h0);
    chk("test_bit", rd[3], 32'h0);
    chk("test_drive", motor_drive_on, 32'h0);
    pins(1'b0, 1'b0, 1'b0);
    cyc(40);
    bus(1'b1, 4'h0, 32'h9);
    cyc(600);
    // Enable low mid-ramp must freeze the speed
    ce <= 1'b0;
    cyc(2);
    rd = 32'(motor_speed);
    cyc(50);
    chk("freeze", motor_speed, rd[10:0]);
    ce <= 1'b1;
    cyc(1500);
    chk("test_speed", motor_speed, 32'h12c);
    bus(1'b1, 4'h0, 32'h1);
    cyc(1500);
    $display("test run done");
    bus(1'b1, 4'h0, 32'h11);
    cyc(5);
    chk("panel", brake_release_on, 32'h1);
    bus(1'b1, 4'h0, 32'h1);
    cyc(5);
    chk("panel_off", brake_release_on, 32'h0);
    $display("panel release done");
    pins(1'b1, 1'b0, 1'b0);
    for (int k = 0; k < 4; k++) begin
      bus(1'b1, 4'h0, cl_ctrl[k]);
      bus(1'b1, 4'h4, 32'(cl_set[k]));
      cyc(7000);
      chk("clamp", motor_speed, cl_exp[k]);
    end
    // Without decel control a zero ramp time jumps at once
    bus(1'b1, 4'h8, 32'h0);
    bus(1'b1, 4'h4, 32'h1f4);
    cyc(10);
    chk("jump", motor_speed, 32'h1f4);
    bus(1'b1, 4'h0, 32'h1);
    bus(1'b1, 4'h4, 32'h190);
    cyc(20);
    chk("ramp_min", motor_speed > 11'h1c2, 32'h1);
    bus(1'b1, 4'h8, 32'h202);
    pins(1'b0, 1'b0, 1'b0);
    cyc(3000);
    $display("setting limits done");
    @(posedge ref_clk);
    source_sel <= 1'b1;
    cyc(10);
    bus(1'b0, 4'hc, 32'h0);
    chk("polarity", rd[28], 32'h1);
    pins(1'b1, 1'b0, 1'b0);
    cyc(1800);
    chk("src_speed", motor_speed, 32'h190);
    pins(1'b0, 1'b0, 1'b0);
    cyc(1800);
    @(posedge ref_clk);
    source_sel <= 1'b0;
    $display("polarity done");
    do_reset(1'b0);
    bus(1'b1, 4'hc, 32'hffffffff);
    for (int k = 0; k < 5; k++) begin
      bus(1'b0, rv_adr[k], 32'h0);
      chk("reg_reset", rd, rv_exp[k]);
    end
    chk("idle_out", {motor_drive_on, inst_stop_on, alarm_on}, 32'h0);
    $display("reset values done");
    do_reset(1'b1);
    cyc(20);
    chk("alarm", alarm_on, 32'h1);
    chk("alarm_code", alarm_code, 32'h2e);
    chk("alarm_drive", motor_drive_on, 32'h0);
    pins(1'b0, 1'b0, 1'b0);
    cyc(10);
    bus(1'b1, 4'h0, 32'h21);
    cyc(5);
    chk("alarm_clr", {alarm_on, alarm_code}, 32'h0);
    $display("power-on alarm done");
    end_of_test();
  end
endmodule : motor_run_stop_command_logic_tb_top

//--- dv/run_input_driver.sv
// Controller model driving the run and coast pins
`timescale 1ns/1ps
module run_input_driver (
  input  wire logic fwd_cmd,
  input  wire logic rev_cmd,
  input  wire logic coast_cmd,
  input  wire logic source_sel,
  output logic      fwd_pin,
  output logic      rev_pin,
  output logic      coast_pin
);
  // Pin level follows the wiring polarity of the controller
  assign fwd_pin   = fwd_cmd ^ source_sel;
  assign rev_pin   = rev_cmd ^ source_sel;
  assign coast_pin = coast_cmd ^ source_sel;
endmodule : run_input_driver

//--- verilog/motor_cfg.svh
// Offsets, field positions, reset values and timing counts
`ifndef MOTOR_CFG_SVH
`define MOTOR_CFG_SVH
`define MRS_OFF_CTRL    4'h0
`define MRS_OFF_SPEED   4'h4
`define MRS_OFF_RAMP    4'h8
`define MRS_OFF_STAT    4'hc
`define MRS_C_DECEL     0
`define MRS_C_COAST     1
`define MRS_C_HZ60      2
`define MRS_C_TEST      3
`define MRS_C_PANEL     4
`define MRS_C_ALMCLR    5
`define MRS_CTRL_RST    6'h01
`define MRS_SPEED_RST   11'h12c
`define MRS_RAMP_RST    16'h0505
`define MRS_TEST_RPM    11'h12c
`define MRS_MIN_DC_RPM  11'h12c
`define MRS_MIN_HZ_RPM  11'h05a
`define MRS_MAX50_RPM   11'h578
`define MRS_MAX60_RPM   11'h640
`define MRS_TMIN_DC     8'h02
`define MRS_TMAX        8'h96
`define MRS_ALM_POWERON 8'h2e
`define MRS_SETTLE      3'h5
`define MRS_CLK_MHZ     100
`define MRS_HALT_MS     400
`define MRS_COAST_MS    100
`define MRS_STEP_US     100
`define MRS_HALT_CYC    (`MRS_HALT_MS * 1000 * `MRS_CLK_MHZ)
`define MRS_COAST_CYC   (`MRS_COAST_MS * 1000 * `MRS_CLK_MHZ)
`define MRS_STEP_CYC    (`MRS_STEP_US * `MRS_CLK_MHZ)
`endif

//--- verilog/motor_pkg.sv
// Types shared by the run and stop command logic
package motor_pkg;
  typedef logic [10:0] rpm_t;
  typedef logic [7:0]  tenth_t;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_RUN   = 3'h1,
    ST_DECEL = 3'h3,
    ST_COAST = 3'h2,
    ST_HALT  = 3'h6,
    ST_TEST  = 3'h7,
    ST_ALARM = 3'h4
  } run_state_e;
endpackage : motor_pkg

//--- verilog/motor_run_stop.sv
// Run and stop command logic for a brake motor speed controller
// Contract
// - Forward input alone runs forward at setting
// - Reverse input alone runs reverse
// - Both inputs off ramps down by deceleration
// - Both inputs on stops instantly, no ramp
// - Brake type selects coasting instead of ramp
// - Run input at power-on raises alarm 46
// - Test operation runs at fixed 300 r/min
// - Test refused while coast input active
// - Panel brake release only at standstill
// - Input polarity sink or source, sink default
// - Decel control limits speed 300 to 1400/1600
// - Decel control limits ramp 0.2 to 15.0 s
// - Without decel control lower limit 90 r/min
// - Coast input releases brake, coasts, blocks start
//
// The Avalon-MM register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "motor_cfg.svh"
module motor_run_stop #(
  parameter int unsigned HALT_CYCLES  = `MRS_HALT_CYC,
  parameter int unsigned COAST_CYCLES = `MRS_COAST_CYC,
  parameter int unsigned STEP_CYCLES  = `MRS_STEP_CYC
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic        ce,
  input  wire logic        forward_run_input,
  input  wire logic        reverse_run_input,
  input  wire logic        coast_release_input,
  input  wire logic        input_polarity_selector,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output logic             motor_drive_on,
  output logic             motor_reverse,
  output motor_pkg::rpm_t  motor_speed,
  output logic             inst_stop_on,
  output logic             brake_release_on,
  output logic             alarm_on,
  output logic [7:0]       alarm_code
);
  import motor_pkg::*;

  ramp_if rif ();

  // Pin synchronisers: bit 0 fwd, 1 rev, 2 coast, 3 polarity
  logic [3:0] s1_r, s2_r, s3_r, lvl_r, lvl_nxt;
  logic       fwd_a, rev_a, free_a;

  always_comb begin
    lvl_nxt = lvl_r;
    for (int i = 0; i < 4; i++) begin
      if (s2_r[i] == s3_r[i]) lvl_nxt[i] = s3_r[i];
    end
    // Source wiring inverts the sensed level
    fwd_a  = lvl_r[0] ^ lvl_r[3];
    rev_a  = lvl_r[1] ^ lvl_r[3];
    free_a = lvl_r[2] ^ lvl_r[3];
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      s1_r  <= '0;
      s2_r  <= '0;
      s3_r  <= '0;
      lvl_r <= '0;
    end else if (ce) begin
      s1_r  <= {input_polarity_selector, coast_release_input,
                reverse_run_input, forward_run_input};
      s2_r  <= s1_r;
      s3_r  <= s2_r;
      lvl_r <= lvl_nxt;
    end
  end

  // Register bus
  logic        wait_r, wait_nxt;
  logic [31:0] rd_r, rd_nxt, cur, wm, mrg;
  logic [5:0]  ctrl_r, ctrl_nxt;
  rpm_t        spd_r, spd_nxt;
  logic [15:0] ramp_r, ramp_nxt;
  logic        test_clr;
  run_state_e  st_r, st_nxt;

  always_comb begin
    unique case (avs_address)
      `MRS_OFF_CTRL:  cur = {26'h0, ctrl_r};
      `MRS_OFF_SPEED: cur = {21'h0, spd_r};
      `MRS_OFF_RAMP:  cur = {16'h0, ramp_r};
      `MRS_OFF_STAT:  cur = {3'h0, lvl_r[3], brake_release_on, motor_speed,
                             alarm_code, 3'h0, alarm_on, motor_reverse,
                             st_r};
      default:        cur = 32'h0;
    endcase
    for (int b = 0; b < 4; b++) begin
      wm[b*8 +: 8] = {8{avs_byteenable[b]}};
    end
    mrg      = (cur & ~wm) | (avs_writedata & wm);
    wait_nxt = 1'b1;
    rd_nxt   = rd_r;
    ctrl_nxt = ctrl_r;
    spd_nxt  = spd_r;
    ramp_nxt = ramp_r;
    ctrl_nxt[`MRS_C_ALMCLR] = 1'b0;
    if (test_clr) ctrl_nxt[`MRS_C_TEST] = 1'b0;
    if (wait_r && (avs_read || avs_write)) begin
      wait_nxt = 1'b0;
      rd_nxt   = avs_read ? cur : 32'h0;
    end
    // Software write lands after the clear, so a set wins
    if (!wait_r && avs_write) begin
      unique case (avs_address)
        `MRS_OFF_CTRL:  ctrl_nxt = mrg[5:0];
        `MRS_OFF_SPEED: spd_nxt  = mrg[10:0];
        `MRS_OFF_RAMP:  ramp_nxt = mrg[15:0];
        default:        ;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      wait_r <= 1'b1;
      rd_r   <= '0;
      ctrl_r <= `MRS_CTRL_RST;
      spd_r  <= `MRS_SPEED_RST;
      ramp_r <= `MRS_RAMP_RST;
    end else if (ce) begin
      wait_r <= wait_nxt;
      rd_r   <= rd_nxt;
      ctrl_r <= ctrl_nxt;
      spd_r  <= spd_nxt;
      ramp_r <= ramp_nxt;
    end
  end

  assign avs_waitrequest = wait_r;
  assign avs_readdata    = rd_r;

  // Setting limits
  function automatic rpm_t lim_rpm(rpm_t v, rpm_t lo, rpm_t hi);
    lim_rpm = (v < lo) ? lo : (v > hi) ? hi : v;
  endfunction : lim_rpm

  function automatic tenth_t lim_t(tenth_t v, tenth_t lo);
    lim_t = (v < lo) ? lo : (v > `MRS_TMAX) ? `MRS_TMAX : v;
  endfunction : lim_t

  logic   dctl, hz60;
  rpm_t   lo_rpm, hi_rpm, set_rpm;
  tenth_t lo_t;

  always_comb begin
    dctl    = ctrl_r[`MRS_C_DECEL];
    hz60    = ctrl_r[`MRS_C_HZ60];
    lo_rpm  = dctl ? `MRS_MIN_DC_RPM : `MRS_MIN_HZ_RPM;
    hi_rpm  = hz60 ? `MRS_MAX60_RPM : `MRS_MAX50_RPM;
    set_rpm = lim_rpm(spd_r, lo_rpm, hi_rpm);
    lo_t    = dctl ? `MRS_TMIN_DC : 8'h00;
    rif.acc_t = lim_t(ramp_r[7:0], lo_t);
    rif.dec_t = lim_t(ramp_r[15:8], lo_t);
    rif.target = (st_r == ST_TEST) ? `MRS_TEST_RPM :
                 (st_r == ST_RUN)  ? set_rpm : 11'h000;
    rif.zero = (st_r == ST_IDLE) || (st_r == ST_COAST) ||
               (st_r == ST_HALT) || (st_r == ST_ALARM);
  end

  // Run state machine
  logic        rev_r, rev_nxt, ready_r, ready_nxt;
  logic [2:0]  set_r, set_nxt;
  logic [31:0] tmr_r, tmr_nxt, tlim;

  always_comb begin
    st_nxt    = st_r;
    rev_nxt   = rev_r;
    tmr_nxt   = tmr_r;
    set_nxt   = set_r;
    ready_nxt = ready_r;
    test_clr  = free_a && ctrl_r[`MRS_C_TEST];
    tlim      = (st_r == ST_HALT) ? HALT_CYCLES : COAST_CYCLES;
    unique case (st_r)
      ST_IDLE: begin
        tmr_nxt = '0;
        if (ready_r && !free_a) begin
          if (fwd_a && !rev_a) begin
            st_nxt  = ST_RUN;
            rev_nxt = 1'b0;
          end else if (rev_a && !fwd_a) begin
            st_nxt  = ST_RUN;
            rev_nxt = 1'b1;
          end else if (!fwd_a && !rev_a && ctrl_r[`MRS_C_TEST]) begin
            st_nxt  = ST_TEST;
            rev_nxt = 1'b0;
          end
        end
      end
      ST_RUN, ST_TEST: begin
        if (free_a) st_nxt = ST_COAST;
        else if (fwd_a && rev_a) st_nxt = ST_HALT;
        else if (st_r == ST_TEST) begin
          if (!ctrl_r[`MRS_C_TEST]) st_nxt = ST_DECEL;
        end else if (!fwd_a && !rev_a) begin
          st_nxt = ctrl_r[`MRS_C_COAST] ? ST_COAST : ST_DECEL;
        end else if (fwd_a == rev_r) begin
          // Reversal ramps through standstill
          st_nxt = ST_DECEL;
        end
      end
      ST_DECEL: begin
        if (free_a) st_nxt = ST_COAST;
        else if (fwd_a && rev_a) st_nxt = ST_HALT;
        else if ((fwd_a ^ rev_a) && (fwd_a != rev_r)) st_nxt = ST_RUN;
        else if (rif.speed == 11'h000) st_nxt = ST_IDLE;
      end
      ST_COAST, ST_HALT: begin
        // Coast time is a guess at run-down, the shaft is not sensed
        if (st_r == ST_COAST && free_a) tmr_nxt = '0;
        else if (tmr_r >= tlim - 32'h1) begin
          st_nxt  = ST_IDLE;
          tmr_nxt = '0;
        end else tmr_nxt = tmr_r + 32'h1;
      end
      ST_ALARM: begin
        if (ctrl_r[`MRS_C_ALMCLR] && !fwd_a && !rev_a) st_nxt = ST_IDLE;
      end
      default: st_nxt = ST_IDLE;
    endcase
    if (!ready_r) begin
      st_nxt = ST_IDLE;
      if (set_r == `MRS_SETTLE) begin
        ready_nxt = 1'b1;
        if (fwd_a || rev_a) st_nxt = ST_ALARM;
      end else set_nxt = set_r + 3'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      st_r    <= ST_IDLE;
      rev_r   <= 1'b0;
      tmr_r   <= '0;
      set_r   <= '0;
      ready_r <= 1'b0;
    end else if (ce) begin
      st_r    <= st_nxt;
      rev_r   <= rev_nxt;
      tmr_r   <= tmr_nxt;
      set_r   <= set_nxt;
      ready_r <= ready_nxt;
    end
  end

  // Registered outputs, taken from the next state
  logic drv_nxt, brk_nxt;

  always_comb begin
    drv_nxt = (st_nxt == ST_RUN) || (st_nxt == ST_DECEL) ||
              (st_nxt == ST_TEST);
    brk_nxt = drv_nxt || free_a ||
              (st_nxt == ST_IDLE && ctrl_r[`MRS_C_PANEL] &&
               rif.speed == 11'h000);
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      motor_drive_on   <= 1'b0;
      motor_reverse    <= 1'b0;
      inst_stop_on     <= 1'b0;
      brake_release_on <= 1'b0;
      alarm_on         <= 1'b0;
      alarm_code       <= 8'h00;
    end else if (ce) begin
      motor_drive_on   <= drv_nxt;
      motor_reverse    <= rev_nxt;
      inst_stop_on     <= (st_nxt == ST_HALT);
      brake_release_on <= brk_nxt;
      alarm_on         <= (st_nxt == ST_ALARM);
      alarm_code       <= (st_nxt == ST_ALARM) ? `MRS_ALM_POWERON : 8'h00;
    end
  end

  assign motor_speed = rif.speed;

  speed_ramp #(
    .STEP_CYCLES (STEP_CYCLES)
  ) u_ramp (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .ce      (ce),
    .rif     (rif)
  );

  default clocking dcb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  AST_FWD_RUN: assert property (
    ce && st_r == ST_IDLE && ready_r && fwd_a && !rev_a && !free_a
    |=> motor_drive_on && !motor_reverse && st_r == ST_RUN)
    else $error("forward input did not start forward run");
  AST_REV_RUN: assert property (
    ce && st_r == ST_IDLE && ready_r && rev_a && !fwd_a && !free_a
    |=> motor_drive_on && motor_reverse)
    else $error("reverse input did not start reverse run");
  AST_DECEL_STOP: assert property (
    ce && st_r == ST_RUN && !fwd_a && !rev_a && !free_a &&
    !ctrl_r[`MRS_C_COAST] |=> st_r == ST_DECEL && rif.target == 11'h000)
    else $error("run release did not start deceleration");
  AST_INST_STOP: assert property (
    ce && (st_r == ST_RUN || st_r == ST_DECEL) && fwd_a && rev_a &&
    !free_a |=> inst_stop_on && !motor_drive_on ##1 motor_speed == 11'h000)
    else $error("both inputs did not stop instantly");
  AST_COAST_TYPE: assert property (
    ce && st_r == ST_RUN && !fwd_a && !rev_a && !free_a &&
    ctrl_r[`MRS_C_COAST] |=> st_r == ST_COAST && !motor_drive_on)
    else $error("coast brake type did not coast");
  AST_POWERON_ALM: assert property (
    ce && !ready_r && set_r == `MRS_SETTLE && (fwd_a || rev_a)
    |=> alarm_on && alarm_code == `MRS_ALM_POWERON && !motor_drive_on)
    else $error("power-on run input did not raise alarm");
  AST_TEST_SPEED: assert property (
    st_r == ST_TEST |-> rif.target == `MRS_TEST_RPM && !motor_reverse)
    else $error("test operation target is not fixed speed");
  AST_TEST_REFUSE: assert property (
    ce && st_r == ST_IDLE && free_a |=> st_r != ST_TEST)
    else $error("test started while coast input active");
  AST_PANEL_REL: assert property (
    brake_release_on && !motor_drive_on && !lvl_r[2] && !lvl_r[3] &&
    $stable(lvl_r) |-> motor_speed == 11'h000 || st_r == ST_ALARM)
    else $error("panel brake release while moving");
  AST_SPEED_DC: assert property (
    st_r == ST_RUN && dctl |-> rif.target >= `MRS_MIN_DC_RPM &&
    rif.target <= (hz60 ? `MRS_MAX60_RPM : `MRS_MAX50_RPM))
    else $error("speed setting outside decel control range");
  AST_RAMP_DC: assert property (
    dctl |-> rif.acc_t >= `MRS_TMIN_DC && rif.dec_t >= `MRS_TMIN_DC &&
    rif.acc_t <= `MRS_TMAX && rif.dec_t <= `MRS_TMAX)
    else $error("ramp time outside decel control range");
  AST_SPEED_HZ: assert property (
    st_r == ST_RUN && !dctl |-> rif.target >= `MRS_MIN_HZ_RPM)
    else $error("speed setting below horizontal limit");
  AST_COAST_IN: assert property (
    ce && (st_r == ST_RUN || st_r == ST_DECEL) && free_a
    |=> st_r == ST_COAST && brake_release_on && !motor_drive_on)
    else $error("coast input did not coast the motor");
  AST_BRAKE_RUN: assert property (
    st_r == ST_RUN || st_r == ST_TEST |-> brake_release_on)
    else $error("brake held while motor driven");
endmodule : motor_run_stop

//--- verilog/ramp_if.sv
// Speed ramp request and answer between controller and ramp generator
`timescale 1ns/1ps
interface ramp_if;
  import motor_pkg::*;
  rpm_t   target;
  tenth_t acc_t;
  tenth_t dec_t;
  logic   zero;
  rpm_t   speed;
  modport ctl (output target, output acc_t, output dec_t, output zero,
               input speed);
  modport gen (input target, input acc_t, input dec_t, input zero,
               output speed);
endinterface : ramp_if

//--- verilog/speed_ramp.sv
// Speed ramp generator, one r/min per ramp step
`timescale 1ns/1ps
`include "motor_cfg.svh"
module speed_ramp #(
  parameter int unsigned STEP_CYCLES = `MRS_STEP_CYC
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic ce,
  ramp_if.gen      rif
);
  import motor_pkg::*;
  logic [31:0] pre_r, pre_nxt;
  tenth_t      div_r, div_nxt;
  rpm_t        speed_r, speed_nxt;
  tenth_t      t_sel;
  logic        tick;

  // Time setting means tenths of a second per 1000 r/min of change
  always_comb begin
    t_sel     = (speed_r < rif.target) ? rif.acc_t : rif.dec_t;
    tick      = (pre_r == STEP_CYCLES - 1);
    pre_nxt   = tick ? 32'h0 : pre_r + 32'h1;
    div_nxt   = div_r;
    speed_nxt = speed_r;
    if (rif.zero) begin
      speed_nxt = '0;
      div_nxt   = '0;
    end else if (speed_r == rif.target) begin
      div_nxt = '0;
    end else if (t_sel == 8'h0) begin
      speed_nxt = rif.target;
    end else if (tick) begin
      if (div_r >= t_sel - 8'h1) begin
        div_nxt   = '0;
        speed_nxt = (speed_r < rif.target) ? speed_r + 11'h1
                                           : speed_r - 11'h1;
      end else begin
        div_nxt = div_r + 8'h1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      pre_r   <= '0;
      div_r   <= '0;
      speed_r <= '0;
    end else if (ce) begin
      pre_r   <= pre_nxt;
      div_r   <= div_nxt;
      speed_r <= speed_nxt;
    end
  end

  assign rif.speed = speed_r;
endmodule : speed_ramp
